// [pmr_host_model.sv]
// serial host side model: one-cycle register strobes
// assumes the bank answers a read within a few cycles
`timescale 1ns/1ps
`default_nettype none
module pmr_host_model (
  // clock
  input wire logic sys_clk,
  // register port toward the bank
  output var pmr_pkg::pmr_req_t host_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  // ----------------
  // bus cycles
  // ----------------
  initial host_req = '{8'h00, 1'b0, 1'b0, 16'h0000};
  // address and data scrambled after the strobe so stale values never help
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) host_req <= '{a, 1'b0, 1'b1, d};
    @(posedge sys_clk) host_req <= '{~a, 1'b0, 1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk) host_req <= '{a, 1'b1, 1'b0, 16'h0000};
    @(posedge sys_clk) host_req <= '{~a, 1'b0, 1'b0, 16'hffff};
    do @(posedge sys_clk) n++; while (!rd_valid && n < 4);
    // a missing answer hands back unknown, which no expectation matches
    d = rd_valid ? rd_data : 16'hxxxx;
  endtask : rd
endmodule : pmr_host_model
`default_nettype wire

// [pmr_pkg.sv]
// constants, carriers and state layout for the result register bank
// assumes one 40 MHz clock; every input comes from logic on that clock

package pmr_pkg;

  // ------------------------------------------------------------------
  // register map and layout
  // ------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int LEVEL_W = 13;
  localparam logic [ADDR_W-1:0] ADDR_BUS = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_POWER = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SCALE = 8'h05;
  localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] SCALE_MASK = 16'hfffe;
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_READY = 1;
  localparam int BIT_LEVEL_LO = 3;
  localparam int BIT_LEVEL_TOP = 12;
  localparam int CUR_SHIFT_DEF = 12;

  // power divider, at product width
  localparam logic [28:0] POWER_DIV = 29'h0001388;

  // operating modes that leave the ready flag alone
  localparam logic [2:0] MODE_PDOWN = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h4;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } pmr_req_t;

  typedef struct packed {
    logic done;
    logic range_32v;
    logic [LEVEL_W-1:0] level;
    logic signed [DATA_W-1:0] shunt;
  } pmr_conv_t;

  typedef struct packed {
    logic wr;
    logic [2:0] mode;
  } pmr_mode_t;

  // gray order along idle, mult, div, commit
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MULT = 2'b01,
    ST_DIV = 2'b11,
    ST_COMMIT = 2'b10
  } pmr_calc_t;

  typedef struct packed {
    pmr_calc_t calc;
    logic [LEVEL_W-1:0] bus_level_bits;
    logic [DATA_W-1:0] power_value_bits;
    logic [DATA_W-1:0] current_result;
    logic [DATA_W-1:0] scaling_bits;
    logic result_ready_flag;
    logic math_overflow_flag;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic [LEVEL_W-1:0] hold_level;
    logic signed [32:0] hold_prod;
    logic [DATA_W-1:0] hold_cur;
    logic [DATA_W-1:0] hold_pwr;
    logic hold_overflow;
  } pmr_state_t;

endpackage : pmr_pkg

// [pmr_result_regs.sv]
// result and scaling register bank of the current and power monitor
// assumes the serial host logic, the conversion engine and the
// configuration register all run on sys_clk; none of them is synchronised

`timescale 1ns/1ps
`default_nettype none

module pmr_result_regs #(
  parameter int CUR_SHIFT = pmr_pkg::CUR_SHIFT_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,

  // register port from the serial host logic
  input wire pmr_pkg::pmr_req_t host_req,
  output logic [15:0] rd_data,
  output logic rd_valid,

  // finished measurement from the conversion engine
  input wire pmr_pkg::pmr_conv_t conv_in,

  // operating mode writes to the configuration register
  input wire pmr_pkg::pmr_mode_t mode_in,

  // status views
  output logic result_ready_flag,
  output logic math_overflow_flag,
  output logic busy
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // true when a wide signed value fits a 16-bit signed result
  function automatic logic fits_s16(input logic signed [32:0] v);
    logic [17:0] top;
    top = v[32:15];
    return (&top) | (~|top);
  endfunction : fits_s16

  // magnitude of a signed 16-bit value; -32768 maps to 32768
  function automatic logic [15:0] mag16(input logic [15:0] v);
    logic [15:0] neg;
    neg = 16'(~v + 16'h0001);
    return v[15] ? neg : v;
  endfunction : mag16

  // bus voltage word as the host sees it
  function automatic logic [15:0] bus_word(input pmr_pkg::pmr_state_t st);
    logic [15:0] w;
    w = pmr_pkg::RST_ZERO;
    w[15:pmr_pkg::BIT_LEVEL_LO] = st.bus_level_bits;
    w[pmr_pkg::BIT_READY] = st.result_ready_flag;
    w[pmr_pkg::BIT_OVERFLOW] = st.math_overflow_flag;
    return w;
  endfunction : bus_word

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  pmr_pkg::pmr_state_t s;
  pmr_pkg::pmr_state_t next_s;

  localparam int LEVEL_W_L = pmr_pkg::LEVEL_W;

  // working values of the combinational process
  logic signed [32:0] cur_wide;
  logic [15:0] cur_mag;
  logic [28:0] pwr_prod;
  logic [28:0] pwr_quot;
  logic [LEVEL_W_L-1:0] lvl_in;
  logic rd_power;
  logic mode_clear;
  logic set_ready;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    cur_wide = '0;
    cur_mag = '0;
    pwr_prod = '0;
    pwr_quot = '0;
    lvl_in = conv_in.level;
    set_ready = 1'b0;

    // read answer is one cycle later, from flops
    next_s.rd_valid = host_req.rd;
    if (host_req.rd) begin
      // results read from live registers, flag state is irrelevant
      case (host_req.addr)
        pmr_pkg::ADDR_BUS: begin
          next_s.rd_data = bus_word(s);
        end
        pmr_pkg::ADDR_POWER: begin
          next_s.rd_data = s.power_value_bits;
        end
        pmr_pkg::ADDR_CURRENT: begin
          next_s.rd_data = s.current_result;
        end
        pmr_pkg::ADDR_SCALE: begin
          next_s.rd_data = s.scaling_bits & pmr_pkg::SCALE_MASK;
        end
        default: begin
          // unmapped addresses answer zero
          next_s.rd_data = pmr_pkg::RST_ZERO;
        end
      endcase
    end

    // only the scaling register takes writes; D0 is dropped
    if (host_req.wr && host_req.addr == pmr_pkg::ADDR_SCALE) begin
      next_s.scaling_bits = host_req.wdata & pmr_pkg::SCALE_MASK;
    end

    // computation sequence, one step per cycle
    case (s.calc)
      pmr_pkg::ST_IDLE: begin
        if (conv_in.done) begin
          // 16V range never shows D15 set
          if (!conv_in.range_32v) begin
            lvl_in[pmr_pkg::BIT_LEVEL_TOP] = 1'b0;
          end
          next_s.hold_level = lvl_in;
          // D0 is always zero, so the full word carries D15..D1
          next_s.hold_prod = 33'(conv_in.shunt) *
            33'($signed({1'b0, s.scaling_bits}));
          next_s.calc = pmr_pkg::ST_MULT;
        end
      end
      pmr_pkg::ST_MULT: begin
        // scale down to the current weight and check the range
        cur_wide = s.hold_prod >>> CUR_SHIFT;
        next_s.hold_cur = cur_wide[15:0];
        next_s.hold_overflow = ~fits_s16(cur_wide);
        next_s.calc = pmr_pkg::ST_DIV;
      end
      pmr_pkg::ST_DIV: begin
        // power is unsigned, taken from the current magnitude
        cur_mag = mag16(s.hold_cur);
        pwr_prod = 29'(cur_mag) * 29'(s.hold_level);
        pwr_quot = pwr_prod / pmr_pkg::POWER_DIV;
        next_s.hold_pwr = pwr_quot[15:0];
        if (|pwr_quot[28:16]) begin
          next_s.hold_overflow = 1'b1;
        end
        next_s.calc = pmr_pkg::ST_COMMIT;
      end
      pmr_pkg::ST_COMMIT: begin
        // every result and flag moves in the same edge
        next_s.bus_level_bits = s.hold_level;
        next_s.current_result = s.hold_cur;
        next_s.power_value_bits = s.hold_pwr;
        next_s.math_overflow_flag = s.hold_overflow;
        set_ready = 1'b1;
        next_s.calc = pmr_pkg::ST_IDLE;
      end
      default: begin
        next_s.calc = pmr_pkg::ST_IDLE;
      end
    endcase

    // ready flag clears; a set in the same cycle wins
    rd_power = host_req.rd && host_req.addr == pmr_pkg::ADDR_POWER;
    mode_clear = mode_in.wr &&
      mode_in.mode != pmr_pkg::MODE_PDOWN &&
      mode_in.mode != pmr_pkg::MODE_DISABLE;
    if (rd_power || mode_clear) begin
      next_s.result_ready_flag = 1'b0;
    end
    if (set_ready) begin
      next_s.result_ready_flag = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------

  // everything comes up zero, flags included
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  // straight from flops, except busy, decoded from the calc state
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign result_ready_flag = s.result_ready_flag;
  assign math_overflow_flag = s.math_overflow_flag;
  assign busy = s.calc != pmr_pkg::ST_IDLE;

endmodule : pmr_result_regs

`default_nettype wire

// [pmr_result_regs_assertions.sv]
// port checks for the result register bank
// assumes it is bound onto pmr_result_regs; one clock domain
`timescale 1ns/1ps
`default_nettype none
module pmr_result_regs_assertions #(
  parameter int CUR_SHIFT = 12
) (
  // watched ports
  input wire logic sys_clk,
  input wire logic reset,
  input wire pmr_pkg::pmr_req_t host_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire pmr_pkg::pmr_conv_t conv_in,
  input wire pmr_pkg::pmr_mode_t mode_in,
  input wire logic result_ready_flag,
  input wire logic math_overflow_flag,
  input wire logic busy
);
  // ----------------
  // checks
  // ----------------
  // idle-bank qualifiers keep a commit from masking a clear
  wire logic pwr_rd = host_req.rd && host_req.addr == pmr_pkg::ADDR_POWER;
  wire logic keep_mode = mode_in.mode == pmr_pkg::MODE_PDOWN ||
    mode_in.mode == pmr_pkg::MODE_DISABLE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (host_req.rd |=> rd_valid)
    else $error("read not answered");
  a_read_pulse: assert property (!host_req.rd |=> !rd_valid)
    else $error("answer without read");
  a_bus_word: assert property (rd_valid && $past(host_req.addr) == pmr_pkg::ADDR_BUS
    |-> rd_data[2:0] == {1'b0, $past(result_ready_flag), $past(math_overflow_flag)})
    else $error("bus word flags wrong");
  a_scale_lsb: assert property (rd_valid && $past(host_req.addr) == pmr_pkg::ADDR_SCALE
    |-> !rd_data[0]) else $error("scaling bit 0 set");
  a_conv_span: assert property (conv_in.done && !busy |=> busy [*3] ##1 !busy)
    else $error("busy span wrong");
  a_ready_set: assert property (conv_in.done && !busy |-> ##4 result_ready_flag)
    else $error("ready not set");
  a_read_clear: assert property (pwr_rd && !busy |=> !result_ready_flag)
    else $error("power read kept ready");
  a_mode_clear: assert property (mode_in.wr && !keep_mode && !busy
    |=> !result_ready_flag) else $error("mode write kept ready");
  a_mode_keep: assert property (mode_in.wr && keep_mode && !pwr_rd && result_ready_flag
    |=> result_ready_flag) else $error("idle mode cleared ready");
  a_flag_commit: assert property ($rose(result_ready_flag)
    || $changed(math_overflow_flag) |-> $past(busy)) else $error("flag moved outside commit");
endmodule : pmr_result_regs_assertions
bind pmr_result_regs pmr_result_regs_assertions #(.CUR_SHIFT(CUR_SHIFT)) chk_u (
  .sys_clk(sys_clk), .reset(reset), .host_req(host_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .conv_in(conv_in), .mode_in(mode_in), .busy(busy),
  .result_ready_flag(result_ready_flag), .math_overflow_flag(math_overflow_flag));
`default_nettype wire

// [pmr_result_regs_test.sv]
// self-checking bench for the result register bank
// assumes the host model drives the register port, this bench the rest
`timescale 1ns/1ps
`default_nettype none
module pmr_result_regs_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  pmr_pkg::pmr_req_t host_req;
  pmr_pkg::pmr_conv_t conv_in = '0;
  pmr_pkg::pmr_mode_t mode_in = '0;
  logic [15:0] rd_data;
  logic rd_valid, ready, overflow, busy;
  logic [15:0] v;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // ----------------
  // clock, hang guard, instances
  // ----------------
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  pmr_host_model host_u (.sys_clk(sys_clk), .host_req(host_req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  pmr_result_regs #(.CUR_SHIFT(12)) dut_u (.sys_clk(sys_clk), .reset(reset),
    .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid), .conv_in(conv_in),
    .mode_in(mode_in), .result_ready_flag(ready), .math_overflow_flag(overflow), .busy(busy));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host_u.rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask : rchk
  // scale 1000h makes current equal to shunt with a shift of 12
  task automatic conv(input logic r32, input logic [12:0] lvl, input logic [15:0] sh);
    @(posedge sys_clk) conv_in <= '{1'b1, r32, lvl, sh};
    @(posedge sys_clk) conv_in.done <= 1'b0;
    @(posedge sys_clk) chk("busy", 16'h0001, {15'h0, busy});
    repeat (3) @(posedge sys_clk);
    chk("busy", 16'h0000, {15'h0, busy});
    chk("ready", 16'h0001, {15'h0, ready});
  endtask : conv
  task automatic mode(input logic [2:0] m, input logic exp);
    @(posedge sys_clk) mode_in <= '{1'b1, m};
    @(posedge sys_clk) mode_in.wr <= 1'b0;
    @(posedge sys_clk) chk("ready", {15'h0, exp}, {15'h0, ready});
  endtask : mode
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ----------------
  // scenarios
  // ----------------
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 2; a < 7; a++) rchk(8'(a), 16'h0000);
    host_u.wr(8'h05, 16'hffff);
    rchk(8'h05, 16'hfffe);
    host_u.wr(8'h04, 16'h1234);
    rchk(8'h04, 16'h0000);
    host_u.wr(8'h05, 16'h1000);
    conv(1'b1, 13'h1f40, 16'hff9c);
    rchk(8'h02, 16'hfa02);
    rchk(8'h04, 16'hff9c);
    rchk(8'h03, 16'h00a0);
    rchk(8'h02, 16'hfa00);
    host_u.wr(8'h05, 16'h2000);
    conv(1'b0, 13'h1f40, 16'h0064);
    rchk(8'h04, 16'h00c8);
    rchk(8'h02, 16'h7a02);
    rchk(8'h03, 16'h009c);
    conv(1'b1, 13'h0001, 16'h0000);
    mode(3'h0, 1'b1);
    mode(3'h4, 1'b1);
    mode(3'h1, 1'b0);
    host_u.wr(8'h05, 16'hfffe);
    conv(1'b1, 13'h1000, 16'h7fff);
    chk("overflow", 16'h0001, {15'h0, overflow});
    conv(1'b1, 13'h0001, 16'h0000);
    chk("overflow", 16'h0000, {15'h0, overflow});
    wrap_up();
  end
endmodule : pmr_result_regs_test
`default_nettype wire
